// ### dv/sptb_bank_test.sv
// Register-level test of the threshold, repeat-run and channel parameter bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin failures++; \
	$display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module sptb_bank_test;
	import sptb_pkg::*;
	localparam int PCYC = 20;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	logic [SPTB_AW-1:0] reg_addr = '0;
	logic [SPTB_DW-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [SPTB_DW-1:0] reg_rdata;
	logic meas_done;
	logic [2:0] meas_chan;
	logic [15:0] meas_result;
	logic [5:0] meas_request;
	logic run_active;
	logic [5:0] cmp_hit;
	logic eng_en = 1'b0;
	logic [3:0] eng_lat = 4'h0;
	logic [15:0] eng_res = 16'h0000;
	int failures = 0;
	int n_checks = 0;
	logic [7:0] mask [4] = '{8'h7F, 8'hFF, 8'h7F, 8'hCF};
	logic [5:0] rst_a [5] = '{6'h2B, 6'h2D, 6'h2C, 6'h29, 6'h3F};
	logic [15:0] thr_t [8] = '{16'h2920, 16'h2A00, 16'h2C12, 16'h2D34, 16'h2501, 16'h2600,
		16'h2730, 16'h2800};
	logic [24:0] cs [11] = '{{8'h03, 16'h1235, 1'b1}, {8'h03, 16'h1233, 1'b0},
		{8'h03, 16'h2001, 1'b0}, {8'h07, 16'h2001, 1'b1}, {8'h04, 16'h2001, 1'b0},
		{8'h05, 16'h0200, 1'b1}, {8'h05, 16'h0050, 1'b0}, {8'h01, 16'h0050, 1'b1},
		{8'h06, 16'h0200, 1'b0}, {8'h06, 16'h3100, 1'b1}, {8'h45, 16'h0200, 1'b0}};
	always #4 sys_clk = ~sys_clk;
	sptb_bank #(.NCH(6), .PERIOD_CYC(PCYC)) i_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .meas_done(meas_done), .meas_chan(meas_chan),
		.meas_result(meas_result), .meas_request(meas_request), .run_active(run_active),
		.cmp_hit(cmp_hit));
	sptb_engine_model i_eng (.sys_clk(sys_clk), .rst(rst), .en(eng_en), .lat(eng_lat),
		.res(eng_res), .want(meas_request), .meas_done(meas_done), .meas_chan(meas_chan),
		.meas_result(meas_result));
	function automatic logic [7:0] pat(input int a);
		return (8'(a) ^ 8'h5A) & mask[(a - 2) % 4];
	endfunction
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic bail();
		failures++;
		report_and_stop();
	endtask
	// Strobe stays up on return so back-to-back writes never assign it twice in one step
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		reg_rd <= 1'b0;
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [5:0] a, output logic [7:0] v);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
		@(posedge sys_clk);
	endtask
	task automatic wait_done();
		int k;
		for (k = 0; k < 60; k++) begin
			@(posedge sys_clk);
			#1;
			if (meas_done === 1'b1) break;
		end
		if (k == 60) bail();
		@(posedge sys_clk);
	endtask
	task automatic meas(input logic [7:0] post, input logic [15:0] r, output logic h);
		wr(SPTB_CH_BASE + 6'h02, post);
		wr(SPTB_REPEAT_RUN, 8'h81);
		reg_wr <= 1'b0;
		eng_en <= 1'b1;
		eng_res <= r;
		wait_done();
		eng_en <= 1'b0;
		#1 h = cmp_hit[0];
		`CHK("run_active", 1'b0, run_active)
		@(posedge sys_clk);
	endtask
	task automatic burst(input logic [7:0] v, input int n);
		int k;
		int got;
		got = 0;
		wr(SPTB_REPEAT_RUN, v);
		reg_wr <= 1'b0;
		eng_en <= 1'b1;
		#1 `CHK("run_active", v[7] && v[6:0] != 7'h00, run_active)
		for (k = 0; k < 300; k++) begin
			@(posedge sys_clk);
			#1;
			if (meas_done === 1'b1) got++;
			if (run_active !== 1'b1) break;
		end
		if (k == 300) bail();
		`CHK("readings", n, got)
		@(posedge sys_clk);
		eng_en <= 1'b0;
		@(posedge sys_clk);
	endtask
	initial begin
		logic [7:0] v;
		logic h;
		int j;
		int k;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		foreach (rst_a[i]) begin
			rd(rst_a[i], v);
			`CHK("reset value", 8'h00, v)
		end
		$display("reset values done");
		for (int a = 2; a <= 25; a++) wr(a[5:0], pat(a));
		for (int a = 2; a <= 25; a++) begin
			rd(a[5:0], v);
			`CHK("channel area", pat(a), v)
		end
		rd(6'h1A, v);
		`CHK("past channel areas", 8'h00, v)
		for (int c = 0; c < 6; c++) wr(6'(4 * c + 5), (c == 0) ? 8'h40 : 8'h00);
		$display("channel areas done");
		foreach (thr_t[i]) wr(thr_t[i][13:8], thr_t[i][7:0]);
		foreach (thr_t[i]) begin
			rd(thr_t[i][13:8], v);
			`CHK("threshold byte", thr_t[i][7:0], v)
		end
		foreach (cs[i]) begin
			meas(cs[i][24:17], cs[i][16:1], h);
			`CHK("cmp_hit", cs[i][0], h)
		end
		wr(SPTB_LOWER_MSB, 8'h00);
		meas(8'h03, 16'h1233, h);
		`CHK("half written bound", 1'b0, h)
		wr(SPTB_LOWER_LSB, 8'h34);
		meas(8'h03, 16'h1233, h);
		`CHK("committed bound", 1'b1, h)
		$display("threshold compare done");
		eng_lat <= 4'h5;
		burst(8'h83, 3);
		rd(SPTB_STATUS, v);
		`CHK("run status", 8'h03, v)
		burst(8'h80, 0);
		burst(8'h00, 0);
		wr(SPTB_REPEAT_RUN, 8'h82);
		reg_wr <= 1'b0;
		eng_en <= 1'b1;
		wait_done();
		burst(8'h82, 2);
		rd(SPTB_REPEAT_RUN, v);
		`CHK("repeat run readback", 8'h82, v)
		$display("repeated run done");
		wr(SPTB_REPEAT_RUN, 8'h00);
		wr(SPTB_PERIOD_MULT1, 8'h02);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
		#1;
		for (k = 0; k < 100 && meas_request[0] !== 1'b1; k++) begin
			@(posedge sys_clk);
			#1;
		end
		if (k == 100) bail();
		for (j = 1; j < 200; j++) begin
			@(posedge sys_clk);
			#1;
			if (meas_request[0] === 1'b1) break;
		end
		`CHK("reading interval", 2 * PCYC, j)
		$display("period timer done");
		@(posedge sys_clk);
		clk_en <= 1'b0;
		wr(SPTB_PERIOD_MULT2, 8'h33);
		clk_en <= 1'b1;
		rd(SPTB_PERIOD_MULT2, v);
		`CHK("frozen write", 8'h00, v)
		$display("clock enable done");
		report_and_stop();
	end
endmodule
`default_nettype wire

// ### dv/sptb_engine_model.sv
// Measurement engine stand-in that answers the bank's reading requests
`timescale 1ns/10ps
`default_nettype none
module sptb_engine_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic en,
	input wire logic [3:0] lat,
	input wire logic [15:0] res,
	input wire logic [5:0] want,
	output logic meas_done,
	output logic [2:0] meas_chan,
	output logic [15:0] meas_result
);
	logic [3:0] cnt_r;
	logic busy_r;
	logic [2:0] first;
	always_comb begin
		first = 3'h0;
		for (int i = 5; i >= 0; i--) begin
			if (want[i]) begin
				first = i[2:0];
			end
		end
	end
	// Between readings the channel is invalid and the data churn, so stale values never match
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			busy_r <= 1'b0;
			cnt_r <= 4'h0;
			meas_done <= 1'b0;
			meas_chan <= 3'h7;
			meas_result <= 16'h0000;
		end else begin
			meas_done <= 1'b0;
			meas_chan <= 3'h7;
			meas_result <= ~meas_result;
			if (!en || want == 6'h00) begin
				busy_r <= 1'b0;
			end else if (!busy_r) begin
				busy_r <= 1'b1;
				cnt_r <= lat;
			end else if (cnt_r != 4'h0) begin
				cnt_r <= cnt_r - 4'h1;
			end else begin
				busy_r <= 1'b0;
				meas_done <= 1'b1;
				meas_chan <= first;
				meas_result <= res;
			end
		end
	end
endmodule
`default_nettype wire

// ### rtl/sptb_bank.sv
// Threshold, repeat-run and per-channel parameter bank with compare logic
//
// Behaviour
// - Lower window bound low byte comes from window_low_bound_lsb bits 7:0.
// - Window thresholding applies only when the channel compare-select enables it.
// - Writing 1 to repeat-run bit 7 with a nonzero count in bits 6:0 starts repeated-run operation.
// - Repeated run takes bits 6:0 readings, then hands reading requests back to the period timers.
// - Six per-channel areas occupy parameter addresses 0x02 to 0x19.
// - Area bytes: conversion, sensitivity, post-processing, schedule.
// - Selected counter sets the multiple of 800 us periods between autonomous readings.
// - Result compares against the threshold chosen by compare-select.
// - Compare-select and counter index both index the global area.
// - Upper window bound high byte comes from its msb parameter.
// - Lower window bound high byte comes from window_low_bound_msb.
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module sptb_bank
	import sptb_pkg::*;
#(
	parameter int NCH = SPTB_NCH,
	parameter int PERIOD_CYC = SPTB_PERIOD_CYC
)(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [SPTB_AW-1:0] reg_addr,
	input wire logic [SPTB_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [SPTB_DW-1:0] reg_rdata,
	input wire logic meas_done,
	input wire logic [2:0] meas_chan,
	input wire logic [15:0] meas_result,
	output logic [NCH-1:0] meas_request,
	output logic run_active,
	output logic [NCH-1:0] cmp_hit
);
	// Refused at elaboration: the address decode is fixed to six areas
	if (NCH != SPTB_NCH) begin : g_bad_nch
		$error("bank serves exactly six channel areas");
	end
	if (PERIOD_CYC < 2) begin : g_bad_period
		$error("period must span at least two cycles");
	end

	localparam int PW = $clog2(PERIOD_CYC);

	typedef struct packed {
		logic [NCH-1:0][3:0][7:0] ch;
		logic [2:0][7:0] pmult;
		logic [1:0][15:0] single_bound;
		logic [7:0] single_stage;
		logic [15:0] window_upper;
		logic [7:0] upper_stage;
		logic [15:0] window_lower;
		logic [7:0] window_low_bound_lsb;
		logic [7:0] window_low_bound_msb;
		logic [7:0] repeat_run_control;
		logic [6:0] readings_taken;
		logic running;
		logic [PW-1:0] period_cnt;
		logic tick;
		logic [7:0] rdata;
		logic [NCH-1:0] hit;
	} sptb_bank_t;

	sptb_bank_t st_r;
	sptb_bank_t st_nxt;
	logic [NCH-1:0] due;
	logic [5:0] ch_off;

	assign ch_off = reg_addr - SPTB_CH_BASE;

	// Each channel gets the period multiple its schedule byte selects
	for (genvar c = 0; c < NCH; c++) begin : g_tmr
		logic [1:0] idx;
		logic [7:0] mult;
		assign idx = st_r.ch[c][SPTB_CH_SCHED][SPTB_CNT_IDX_LSB +: 2];
		assign mult = (idx == 2'h0) ? 8'h00 : st_r.pmult[idx - 2'h1];
		sptb_period_timer u_tmr (
			.sys_clk(sys_clk),
			.rst(rst),
			.clk_en(clk_en),
			.period_tick(st_r.tick && !st_r.running),
			.period_multiple(mult),
			.reading_due(due[c])
		);
	end

	function automatic logic compare(input logic [7:0] post, input logic [15:0] res,
		input logic [1:0][15:0] sb, input logic [15:0] up, input logic [15:0] lo);
		logic pol;
		logic r;
		pol = post[SPTB_CMP_POL_BIT];
		r = 1'b0;
		case (post[SPTB_CMP_SEL_LSB +: 2])
			SPTB_CMP_SINGLE0: r = pol ? (res > sb[0]) : (res < sb[0]);
			SPTB_CMP_SINGLE1: r = pol ? (res > sb[1]) : (res < sb[1]);
			// Window bounds only matter when selected here
			SPTB_CMP_WINDOW: r = pol ? (res > up || res < lo) : (res <= up && res >= lo);
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	always_comb begin
		st_nxt = st_r;
		st_nxt.hit = '0;
		st_nxt.tick = 1'b0;
		if (st_r.period_cnt == PW'(PERIOD_CYC - 1)) begin
			st_nxt.period_cnt = '0;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.period_cnt = st_r.period_cnt + PW'(1);
		end
		// Readings from the engine: count them and evaluate thresholds
		if (meas_done && 32'(meas_chan) < NCH) begin
			// Wide results are not compared; 24-bit data would be truncated
			if (!st_r.ch[meas_chan][SPTB_CH_POST][SPTB_WIDE_BIT]) begin
				st_nxt.hit[meas_chan] = compare(st_r.ch[meas_chan][SPTB_CH_POST],
					meas_result, st_r.single_bound, st_r.window_upper,
					st_r.window_lower);
			end
			if (st_r.running) begin
				if (st_r.readings_taken + 7'h01 >= st_r.repeat_run_control[6:0]) begin
					st_nxt.running = 1'b0;
				end
				st_nxt.readings_taken = st_r.readings_taken + 7'h01;
			end
		end
		if (reg_wr) begin
			if (reg_addr >= SPTB_CH_BASE && reg_addr <= SPTB_CH_LAST) begin
				st_nxt.ch[ch_off[5:2]][ch_off[1:0]] = reg_wdata;
			end
			case (reg_addr)
				SPTB_PERIOD_MULT1: st_nxt.pmult[0] = reg_wdata;
				SPTB_PERIOD_MULT2: st_nxt.pmult[1] = reg_wdata;
				SPTB_PERIOD_MULT3: st_nxt.pmult[2] = reg_wdata;
				SPTB_SINGLE0_MSB, SPTB_SINGLE1_MSB: st_nxt.single_stage = reg_wdata;
				// Bound commits on the low byte, so msb then lsb is atomic
				SPTB_SINGLE0_LSB: st_nxt.single_bound[0] = {st_r.single_stage, reg_wdata};
				SPTB_SINGLE1_LSB: st_nxt.single_bound[1] = {st_r.single_stage, reg_wdata};
				SPTB_UPPER_MSB: st_nxt.upper_stage = reg_wdata;
				SPTB_UPPER_LSB: st_nxt.window_upper = {st_r.upper_stage, reg_wdata};
				SPTB_LOWER_MSB: st_nxt.window_low_bound_msb = reg_wdata;
				SPTB_LOWER_LSB: begin
					st_nxt.window_low_bound_lsb = reg_wdata;
					st_nxt.window_lower = {st_r.window_low_bound_msb, reg_wdata};
				end
				SPTB_REPEAT_RUN: begin
					st_nxt.repeat_run_control = reg_wdata;
					st_nxt.readings_taken = 7'h00;
					st_nxt.running = reg_wdata[SPTB_RUN_EN_BIT] && reg_wdata[6:0] != 7'h00;
				end
				default: ;
			endcase
		end
		st_nxt.rdata = 8'h00;
		if (reg_rd) begin
			if (reg_addr >= SPTB_CH_BASE && reg_addr <= SPTB_CH_LAST) begin
				st_nxt.rdata = st_r.ch[ch_off[5:2]][ch_off[1:0]];
			end
			case (reg_addr)
				SPTB_PERIOD_MULT1: st_nxt.rdata = st_r.pmult[0];
				SPTB_PERIOD_MULT2: st_nxt.rdata = st_r.pmult[1];
				SPTB_PERIOD_MULT3: st_nxt.rdata = st_r.pmult[2];
				SPTB_SINGLE0_MSB: st_nxt.rdata = st_r.single_bound[0][15:8];
				SPTB_SINGLE0_LSB: st_nxt.rdata = st_r.single_bound[0][7:0];
				SPTB_SINGLE1_MSB: st_nxt.rdata = st_r.single_bound[1][15:8];
				SPTB_SINGLE1_LSB: st_nxt.rdata = st_r.single_bound[1][7:0];
				SPTB_UPPER_MSB: st_nxt.rdata = st_r.upper_stage;
				SPTB_UPPER_LSB: st_nxt.rdata = st_r.window_upper[7:0];
				SPTB_LOWER_MSB: st_nxt.rdata = st_r.window_low_bound_msb;
				SPTB_LOWER_LSB: st_nxt.rdata = st_r.window_low_bound_lsb;
				SPTB_REPEAT_RUN: st_nxt.rdata = st_r.repeat_run_control;
				SPTB_STATUS: st_nxt.rdata = {st_r.running, st_r.readings_taken};
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_r <= '0;
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

	// Burst mode requests every enabled channel; otherwise the timers pace them
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			meas_request[c] = st_r.running ? (st_r.ch[c][SPTB_CH_SCHED][SPTB_CNT_IDX_LSB +: 2] != 2'h0)
				: due[c];
		end
	end
	assign run_active = st_r.running;
	assign cmp_hit = st_r.hit;
	assign reg_rdata = st_r.rdata;

	a_lower_commit: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && reg_wr && reg_addr == SPTB_LOWER_LSB
		|=> st_r.window_lower == {$past(st_r.window_low_bound_msb), $past(reg_wdata)})
		else $error("lower bound not assembled from its two bytes");
	a_msb_no_commit: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && reg_wr && (reg_addr == SPTB_LOWER_MSB || reg_addr == SPTB_UPPER_MSB)
		|=> $stable(st_r.window_lower) && $stable(st_r.window_upper))
		else $error("bound changed on a high byte write");
	a_upper_commit: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && reg_wr && reg_addr == SPTB_UPPER_LSB
		|=> st_r.window_upper[15:8] == $past(st_r.upper_stage))
		else $error("upper bound high byte wrong");
	a_run_start: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && reg_wr && reg_addr == SPTB_REPEAT_RUN && reg_wdata[7] && reg_wdata[6:0] != 7'h00
		|=> run_active && st_r.readings_taken == 7'h00)
		else $error("repeated run did not start");
	a_zero_count: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && reg_wr && reg_addr == SPTB_REPEAT_RUN && reg_wdata[6:0] == 7'h00
		|=> !run_active)
		else $error("zero count run started");
	a_run_stops: assert property (@(posedge sys_clk) disable iff (rst)
		run_active && clk_en && meas_done && 32'(meas_chan) < NCH && !reg_wr
		&& st_r.readings_taken + 7'h01 >= st_r.repeat_run_control[6:0]
		|=> !run_active)
		else $error("run did not stop at count");
	a_no_cmp_off: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && meas_done && 32'(meas_chan) < NCH
		&& st_r.ch[meas_chan][SPTB_CH_POST][1:0] == SPTB_CMP_OFF
		|=> !cmp_hit[$past(meas_chan)])
		else $error("hit on channel with comparison off");
	a_chan_write: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && reg_wr && reg_addr == SPTB_CH_BASE + 6'h02
		|=> st_r.ch[0][SPTB_CH_POST] == $past(reg_wdata))
		else $error("channel area byte order wrong");
	a_read_data: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && reg_rd && reg_addr == SPTB_REPEAT_RUN && !reg_wr
		|=> reg_rdata == $past(st_r.repeat_run_control))
		else $error("repeat control readback wrong");
	a_single0_commit: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && reg_wr && reg_addr == SPTB_SINGLE0_LSB
		|=> st_r.single_bound[0] == {$past(st_r.single_stage), $past(reg_wdata)})
		else $error("single bound 0 not assembled from its two bytes");
	a_single1_commit: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && reg_wr && reg_addr == SPTB_SINGLE1_LSB
		|=> st_r.single_bound[1] == {$past(st_r.single_stage), $past(reg_wdata)})
		else $error("single bound 1 not assembled from its two bytes");
	a_lower_stage: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && reg_wr && reg_addr == SPTB_LOWER_MSB
		|=> st_r.window_low_bound_msb == $past(reg_wdata))
		else $error("lower bound high byte not staged");
	a_chan_first: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && reg_wr && reg_addr == SPTB_CH_BASE
		|=> st_r.ch[0][SPTB_CH_CONV] == $past(reg_wdata))
		else $error("first channel area byte misplaced");
	a_chan_last: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && reg_wr && reg_addr == SPTB_CH_LAST
		|=> st_r.ch[NCH-1][SPTB_CH_SCHED] == $past(reg_wdata))
		else $error("last channel area byte misplaced");
	a_tick_pulse: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && st_r.tick |=> !st_r.tick)
		else $error("period tick longer than one cycle");
	a_count_bound: assert property (@(posedge sys_clk) disable iff (rst)
		run_active |-> st_r.readings_taken < st_r.repeat_run_control[6:0])
		else $error("run continued past its reading count");
	a_hit_needs_read: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && !(meas_done && 32'(meas_chan) < NCH) |=> cmp_hit == '0)
		else $error("compare hit without a reading");

	c_run: cover property (@(posedge sys_clk) disable iff (rst) run_active ##1 !run_active);
	c_hit: cover property (@(posedge sys_clk) disable iff (rst) |cmp_hit);
	c_due: cover property (@(posedge sys_clk) disable iff (rst) |due);
	c_low: cover property (@(posedge sys_clk) disable iff (rst)
		reg_wr && reg_addr == SPTB_LOWER_LSB);
	c_restart: cover property (@(posedge sys_clk) disable iff (rst)
		run_active && reg_wr && reg_addr == SPTB_REPEAT_RUN);
endmodule
`default_nettype wire

// ### rtl/sptb_period_timer.sv
// Per-channel autonomous reading timer in units of the base period
`timescale 1ns/10ps
`default_nettype none
module sptb_period_timer
	import sptb_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic period_tick,
	input wire logic [7:0] period_multiple,
	output logic reading_due
);
	typedef struct packed {
		logic [7:0] cnt;
		logic due;
	} sptb_tmr_t;
	sptb_tmr_t st_r;
	sptb_tmr_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.due = 1'b0;
		// A zero multiple parks the channel rather than firing every period
		if (period_tick && period_multiple != 8'h00) begin
			if (st_r.cnt + 8'h01 >= period_multiple) begin
				st_nxt.cnt = 8'h00;
				st_nxt.due = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_r <= '0;
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

	assign reading_due = st_r.due;

	a_due_on_tick: assert property (@(posedge sys_clk) disable iff (rst)
		clk_en && !(period_tick && period_multiple != 8'h00) |=> !reading_due)
		else $error("reading fired without a period tick");
endmodule
`default_nettype wire

// ### rtl/sptb_pkg.sv
// Shared constants for the sensor parameter threshold and burst bank
package sptb_pkg;
	localparam int SPTB_AW = 6;
	localparam int SPTB_DW = 8;
	localparam int SPTB_NCH = 6;
	// Parameter addresses
	localparam logic [5:0] SPTB_CH_BASE = 6'h02;
	localparam logic [5:0] SPTB_CH_LAST = 6'h19;
	localparam logic [5:0] SPTB_PERIOD_MULT1 = 6'h22;
	localparam logic [5:0] SPTB_PERIOD_MULT2 = 6'h23;
	localparam logic [5:0] SPTB_PERIOD_MULT3 = 6'h24;
	localparam logic [5:0] SPTB_SINGLE0_MSB = 6'h25;
	localparam logic [5:0] SPTB_SINGLE0_LSB = 6'h26;
	localparam logic [5:0] SPTB_SINGLE1_MSB = 6'h27;
	localparam logic [5:0] SPTB_SINGLE1_LSB = 6'h28;
	localparam logic [5:0] SPTB_UPPER_MSB = 6'h29;
	localparam logic [5:0] SPTB_UPPER_LSB = 6'h2A;
	localparam logic [5:0] SPTB_REPEAT_RUN = 6'h2B;
	localparam logic [5:0] SPTB_LOWER_MSB = 6'h2C;
	localparam logic [5:0] SPTB_LOWER_LSB = 6'h2D;
	localparam logic [5:0] SPTB_STATUS = 6'h30;
	localparam logic [7:0] SPTB_RESET_VAL = 8'h00;
	// Channel area byte order and fields
	localparam int SPTB_CH_CONV = 0;
	localparam int SPTB_CH_SENS = 1;
	localparam int SPTB_CH_POST = 2;
	localparam int SPTB_CH_SCHED = 3;
	localparam int SPTB_CMP_SEL_LSB = 0;
	localparam int SPTB_CMP_POL_BIT = 2;
	localparam int SPTB_WIDE_BIT = 6;
	localparam int SPTB_CNT_IDX_LSB = 6;
	localparam int SPTB_RUN_EN_BIT = 7;
	// Compare-select encodings
	localparam logic [1:0] SPTB_CMP_OFF = 2'h0;
	localparam logic [1:0] SPTB_CMP_SINGLE0 = 2'h1;
	localparam logic [1:0] SPTB_CMP_SINGLE1 = 2'h2;
	localparam logic [1:0] SPTB_CMP_WINDOW = 2'h3;
	// Period unit
	localparam int SPTB_CLK_MHZ = 125;
	localparam int SPTB_PERIOD_US = 800;
	localparam int SPTB_PERIOD_CYC = SPTB_PERIOD_US * SPTB_CLK_MHZ;
endpackage
